// ### src/irwd_pkg.sv
/*
 * Shared types and constants of the interrupt routing and wake detect block.
 * Assumes one system clock and one active-low reset.
 */
package irwd_pkg;

    localparam int NUM_SRC = 8;
    localparam int NUM_WAKE = 4;
    localparam int SRC_W = 3;
    localparam int PRIO_W = 2;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    localparam logic [2:0] MODE_RESET = 3'h2;
    localparam logic MASK_RESET = 1'h1;
    localparam logic [7:0] CLEAR_CODE_BASE = 8'h10;

    // Detection mode of a wake detector: active level or edge.
    typedef enum logic [2:0]
    {
        IRWD_LVL_LOW = 3'h0,
        IRWD_LVL_HIGH = 3'h1,
        IRWD_EDGE_RISE = 3'h2,
        IRWD_EDGE_FALL = 3'h3
    } irwd_mode_t;

    // Per-source wake control.
    typedef struct packed
    {
        logic enable;
        irwd_mode_t mode;
    } irwd_wake_cfg_t;

    // Request presented to the core.
    typedef struct packed
    {
        logic valid;
        logic [SRC_W-1:0] id;
        logic [PRIO_W-1:0] prio;
    } irwd_req_t;

endpackage

// ### src/irwd_wake_detect.sv
/*
 * One wake detector of the clock generator unit: level or edge detection with a held request.
 * Assumes the input is already synchronised to clk.
 */
`timescale 1ns/1ns
module irwd_wake_detect
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_in,
    input wire logic is_pin,
    input irwd_pkg::irwd_wake_cfg_t cfg,
    input wire logic clear,
    output logic req_out
);

    logic prev;
    logic held;
    logic next_prev;
    logic next_held;
    logic edge_hit;

    always_comb
    begin
        next_prev = req_in;
        edge_hit = 1'b0;
        case (cfg.mode)
            irwd_pkg::IRWD_EDGE_RISE: edge_hit = req_in & ~prev;
            irwd_pkg::IRWD_EDGE_FALL: edge_hit = ~req_in & prev;
            default: edge_hit = 1'b0;
        endcase
        // A new edge in the clearing cycle wins, so no event is lost.
        next_held = held;
        if (clear)
            next_held = 1'b0;
        if (cfg.enable && edge_hit)
            next_held = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev <= 1'b0;
            held <= 1'b0;
        end
        else
        begin
            prev <= next_prev;
            held <= next_held;
        end
    end

    // Levels are passed straight through and never held; peripherals only get edge modes.
    always_comb
    begin
        req_out = held;
        if (cfg.enable && is_pin && cfg.mode == irwd_pkg::IRWD_LVL_HIGH)
            req_out = req_in;
        else if (cfg.enable && is_pin && cfg.mode == irwd_pkg::IRWD_LVL_LOW)
            req_out = ~req_in;
        else if (!cfg.enable)
            req_out = 1'b0;
    end

endmodule

// ### src/irwd_top.sv
/*
 * Interrupt routing with wake detection and a priority arbiter towards the core.
 * Assumes the core acknowledges the presented request with a one-cycle accept and
 * stacks its context on that accept; configuration arrives as plain ports.
 */
// How it works
// - two-bit priority per source, 0 most urgent
// - only the most urgent pending request presented
// - equal priority picks the lowest source number
// - global mask blocks all but non-maskable, hard faults
// - faults under global mask escalate to hard fault
// - user level cannot change the global mask
// - set-pending write makes a source pending
// - port input enable gates pin interrupt input
// - wake sources reach core only via detector
// - per wake source active level and enable
// - clear code drops the held wake request
// - core saves context before the service routine
// - high level on a line means request; a wake pin in IRWD_LVL_LOW mode requests on a low level instead
// - pins get levels or edges, peripherals edges
// - detected edge held until software clears it
// - level requests latched only in pending until accepted
`timescale 1ns/1ns
module irwd_top #(
    parameter int NUM_SRC = irwd_pkg::NUM_SRC,
    parameter int NUM_WAKE = irwd_pkg::NUM_WAKE
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_SRC-1:0] periph_irq,
    input wire logic [NUM_SRC-1:0] pin_irq,
    input wire logic [NUM_SRC-1:0] src_is_pin,
    input wire logic [NUM_SRC-1:0] port_input_enable,
    input wire logic [NUM_SRC-1:0] set_enable,
    input wire logic [NUM_SRC*irwd_pkg::PRIO_W-1:0] prio_cfg,
    input wire logic [NUM_SRC-1:0] set_pending,
    input irwd_pkg::irwd_wake_cfg_t [NUM_WAKE-1:0] wake_interrupt_mode_ctrl,
    input wire logic wake_request_clear_we,
    input wire logic [7:0] wake_request_clear,
    input wire logic mask_we,
    input wire logic mask_wdata,
    input wire logic privileged,
    input wire logic fault_in,
    input wire logic nmi_in,
    input wire logic core_accept,
    output irwd_pkg::irwd_req_t core_req,
    output logic global_interrupt_mask,
    output logic [NUM_SRC-1:0] pending,
    output logic hard_fault,
    output logic nmi_out,
    output logic save_context
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers.

    logic rst_meta;
    logic rst_sync_n;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    logic [NUM_SRC-1:0] pin_meta;
    logic [NUM_SRC-1:0] pin_sync;
    logic nmi_meta;
    logic nmi_sync;
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            nmi_meta <= 1'b0;
            nmi_sync <= 1'b0;
        end
        else
        begin
            pin_meta <= pin_irq;
            pin_sync <= pin_meta;
            nmi_meta <= nmi_in;
            nmi_sync <= nmi_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Source lines: pins gated by input enable, wake sources routed through detectors.

    logic [NUM_SRC-1:0] raw_line;
    logic [NUM_SRC-1:0] line;
    always_comb
    begin
        for (int i = 0; i < NUM_SRC; i++)
            raw_line[i] = src_is_pin[i] ? (pin_sync[i] & port_input_enable[i]) : periph_irq[i];
    end

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : gen_route
            if (g < NUM_WAKE)
            begin : gen_wake
                logic clr;
                logic det_out;
                // The low-level mode inverts its input, so a disabled pin would look active; gate after the detector.
                assign clr = wake_request_clear_we &&
                    wake_request_clear == irwd_pkg::CLEAR_CODE_BASE + 8'(g);
                irwd_wake_detect u_det
                (
                    .clk(clk),
                    .rst_n(rst_sync_n),
                    .req_in(raw_line[g]),
                    .is_pin(src_is_pin[g]),
                    .cfg(wake_interrupt_mode_ctrl[g]),
                    .clear(clr),
                    .req_out(det_out)
                );
                assign line[g] = det_out & (~src_is_pin[g] | port_input_enable[g]);
            end
            else
            begin : gen_direct
                assign line[g] = raw_line[g];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Pending flags and global mask.

    logic [NUM_SRC-1:0] next_pending;
    logic next_mask;
    logic [NUM_SRC-1:0] accept_vec;
    always_comb
    begin
        accept_vec = '0;
        if (core_accept && core_req.valid)
            accept_vec[core_req.id] = 1'b1;
        // A request in the accept cycle sets the flag again, so it is not lost.
        next_pending = (pending & ~accept_vec) | line | set_pending;
        next_mask = global_interrupt_mask;
        if (mask_we && privileged)
            next_mask = mask_wdata;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pending <= '0;
            global_interrupt_mask <= irwd_pkg::MASK_RESET;
        end
        else
        begin
            pending <= next_pending;
            global_interrupt_mask <= next_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Arbiter: lowest level wins, then lowest index.

    function automatic logic [irwd_pkg::PRIO_W-1:0] prio_of(input logic [NUM_SRC*irwd_pkg::PRIO_W-1:0] cfg,
                                                             input int idx);
        prio_of = cfg[idx*irwd_pkg::PRIO_W +: irwd_pkg::PRIO_W];
    endfunction

    irwd_pkg::irwd_req_t best;
    irwd_pkg::irwd_req_t next_req;
    always_comb
    begin
        best = '0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (pending[i] && set_enable[i] && !accept_vec[i] &&
                (!best.valid || prio_of(prio_cfg, i) < best.prio))
            begin
                best.valid = 1'b1;
                best.id = irwd_pkg::SRC_W'(i);
                best.prio = prio_of(prio_cfg, i);
            end
        end
        next_req = best;
        if (global_interrupt_mask)
            next_req = '0;
    end

    logic next_fault;
    logic next_save;
    always_comb
    begin
        // Any fault is promoted while the mask is set; without the mask it still lands here.
        next_fault = fault_in;
        next_save = core_accept && core_req.valid;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            core_req <= '0;
            hard_fault <= 1'b0;
            nmi_out <= 1'b0;
            save_context <= 1'b0;
        end
        else
        begin
            core_req <= next_req;
            hard_fault <= next_fault;
            nmi_out <= nmi_sync;
            save_context <= next_save;
        end
    end

endmodule

// ### test/irwd_top_monitor.sv
/* Checker of the interrupt routing block.
   Assumes the ports of irwd_top and a single clock domain. */
`timescale 1ns/1ns
module irwd_top_monitor #(
    parameter int NUM_SRC = irwd_pkg::NUM_SRC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_SRC-1:0] set_pending,
    input wire logic [NUM_SRC*irwd_pkg::PRIO_W-1:0] prio_cfg,
    input wire logic mask_we,
    input wire logic mask_wdata,
    input wire logic privileged,
    input wire logic fault_in,
    input wire logic nmi_in,
    input wire logic core_accept,
    input irwd_pkg::irwd_req_t core_req,
    input wire logic global_interrupt_mask,
    input wire logic [NUM_SRC-1:0] pending,
    input wire logic hard_fault,
    input wire logic nmi_out,
    input wire logic save_context
);
    logic [NUM_SRC-1:0] pend_q;
    logic [1:0] cfg_prio;
    always_ff @(posedge clk) pend_q <= pending;
    always_comb cfg_prio = prio_cfg[core_req.id*2 +: 2];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ctx_on_accept: assert property (core_accept && core_req.valid |=> save_context)
        else $error("no save_context");
    a_mask_blocks_req: assert property (global_interrupt_mask && $past(global_interrupt_mask) |-> !core_req.valid)
        else $error("request under mask");
    a_user_mask_kept: assert property (mask_we && !privileged |=> $stable(global_interrupt_mask))
        else $error("user changed mask");
    a_priv_mask_set: assert property (mask_we && privileged |=> global_interrupt_mask == $past(mask_wdata))
        else $error("mask write lost");
    a_fault_to_hard: assert property (fault_in |=> hard_fault)
        else $error("no hard fault");
    a_nmi_passes: assert property ($rose(nmi_in) |-> ##[1:4] nmi_out)
        else $error("nmi blocked");
    a_set_makes_pend: assert property (|set_pending |=> (pending & $past(set_pending)) == $past(set_pending))
        else $error("set-pending lost");
    a_req_was_pend: assert property (core_req.valid |-> pend_q[core_req.id])
        else $error("request not pending");
    a_prio_field: assert property (core_req.valid |-> core_req.prio == cfg_prio)
        else $error("wrong priority");
    c_accept: cover property (core_accept && core_req.valid);
    c_user_write: cover property (mask_we && !privileged);
    c_fault: cover property (fault_in);
endmodule
bind irwd_top irwd_top_monitor #(.NUM_SRC(NUM_SRC)) u_monitor (.*);

// ### test/irwd_core_model.sv
/* Behavioural core that accepts the presented request, promptly or slowly.
   Assumes core_req of irwd_top on the same clock. */
`timescale 1ns/1ns
module irwd_core_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input irwd_pkg::irwd_req_t core_req,
    output logic core_accept,
    output logic [2:0] last_id,
    output logic [7:0] n_acc
);
    logic [2:0] gap;
    // A gap after each accept lets the pending flag drop before the next look.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_accept <= 1'b0;
            gap <= 3'h0;
            last_id <= 3'h0;
            n_acc <= 8'h00;
        end
        else if (core_accept)
        begin
            core_accept <= 1'b0;
            gap <= slow ? 3'h6 : 3'h2;
        end
        else if (gap != 3'h0)
            gap <= gap - 3'h1;
        else if (core_req.valid === 1'b1)
        begin
            core_accept <= 1'b1;
            last_id <= core_req.id;
            n_acc <= n_acc + 8'h01;
        end
    end
endmodule

// ### test/irwd_top_test.sv
/* Testbench of irwd_top: masking, arbitration, pin gating and wake holding.
   Assumes irwd_core_model as the core and the bound checker. */
`timescale 1ns/1ns
module irwd_top_test;
    logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, core_accept;
    logic [7:0] periph_irq = 8'h00, pin_irq = 8'h00, src_is_pin = 8'h00, port_input_enable = 8'h00;
    logic [7:0] set_enable = 8'hFF, set_pending = 8'h00, wake_request_clear = 8'h00;
    logic [15:0] prio_cfg = 16'h0000;
    irwd_pkg::irwd_wake_cfg_t [3:0] wake_interrupt_mode_ctrl = '0;
    logic wake_request_clear_we = 1'b0, mask_we = 1'b0, mask_wdata = 1'b0, privileged = 1'b0;
    logic fault_in = 1'b0, nmi_in = 1'b0, global_interrupt_mask, hard_fault, nmi_out, save_context;
    irwd_pkg::irwd_req_t core_req;
    logic [7:0] pending, n_acc, n0;
    logic [2:0] last_id;
    int n_mismatch = 0, n_checks = 0;
    always #4 clk = ~clk;
    irwd_top dut (.*);
    irwd_core_model core (.clk(clk), .rst_n(rst_n), .slow(slow), .core_req(core_req),
        .core_accept(core_accept), .last_id(last_id), .n_acc(n_acc));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wmask(input logic p, input logic d);
        @(posedge clk);
        mask_we <= 1'b1;
        mask_wdata <= d;
        privileged <= p;
        @(posedge clk);
        mask_we <= 1'b0;
    endtask
    task automatic wclr(input logic [7:0] code);
        @(posedge clk);
        wake_request_clear_we <= 1'b1;
        wake_request_clear <= code;
        @(posedge clk);
        wake_request_clear_we <= 1'b0;
    endtask
    task automatic next_acc(input logic [7:0] id);
        #1;
        n0 = n_acc;
        repeat (40) if (n_acc == n0) #8;
        chk("accepted id", id, {5'h00, last_id});
    endtask
    task automatic t_mask;
        chk("reset mask", 8'h01, {7'h00, global_interrupt_mask});
        wmask(1'b0, 1'b0);
        tick(2);
        chk("user mask", 8'h01, {7'h00, global_interrupt_mask});
        @(posedge clk);
        set_pending <= 8'h10;
        fault_in <= 1'b1;
        nmi_in <= 1'b1;
        @(posedge clk);
        set_pending <= 8'h00;
        fault_in <= 1'b0;
        nmi_in <= 1'b0;
        #1;
        chk("hard fault", 8'h01, {7'h00, hard_fault});
        tick(2);
        chk("nmi out", 8'h01, {7'h00, nmi_out});
        tick(2);
        chk("masked pending", 8'h10, pending);
        chk("masked valid", 8'h00, {7'h00, core_req.valid});
        wmask(1'b1, 1'b0);
        next_acc(8'h04);
        tick(1);
        chk("save context", 8'h01, {7'h00, save_context});
        tick(2);
        chk("pending cleared", 8'h00, pending);
        $display("test mask done");
    endtask
    task automatic t_prio;
        wmask(1'b1, 1'b1);
        prio_cfg <= 16'hD600;
        slow <= 1'b1;
        @(posedge clk);
        set_pending <= 8'hF0;
        @(posedge clk);
        set_pending <= 8'h00;
        wmask(1'b1, 1'b0);
        next_acc(8'h05);
        next_acc(8'h06);
        next_acc(8'h04);
        next_acc(8'h07);
        @(posedge clk);
        slow <= 1'b0;
        $display("test prio done");
    endtask
    task automatic t_pin;
        @(posedge clk);
        src_is_pin <= 8'h20;
        pin_irq <= 8'h20;
        tick(8);
        chk("gated pin", 8'h00, pending);
        @(posedge clk);
        port_input_enable <= 8'h20;
        next_acc(8'h05);
        @(posedge clk);
        pin_irq <= 8'h00;
        tick(12);
        $display("test pin done");
    endtask
    task automatic t_level;
        wmask(1'b1, 1'b1);
        src_is_pin <= 8'h22;
        wake_interrupt_mode_ctrl[1] <= {1'b0, irwd_pkg::IRWD_LVL_LOW};
        wclr(irwd_pkg::CLEAR_CODE_BASE + 8'h01);
        wake_interrupt_mode_ctrl[1].enable <= 1'b1;
        tick(6);
        chk("disabled low pin", 8'h00, pending & 8'h02);
        @(posedge clk);
        port_input_enable <= 8'h22;
        tick(6);
        chk("low level pin", 8'h02, pending & 8'h02);
        @(posedge clk);
        pin_irq <= 8'h02;
        tick(6);
        wmask(1'b1, 1'b0);
        next_acc(8'h01);
        tick(6);
        n0 = n_acc;
        tick(12);
        chk("level not held", n0, n_acc);
        $display("test level done");
    endtask
    task automatic t_wake;
        wmask(1'b1, 1'b1);
        wake_interrupt_mode_ctrl[0] <= {1'b0, irwd_pkg::IRWD_EDGE_RISE};
        wclr(irwd_pkg::CLEAR_CODE_BASE);
        wake_interrupt_mode_ctrl[0].enable <= 1'b1;
        @(posedge clk);
        periph_irq <= 8'h01;
        @(posedge clk);
        periph_irq <= 8'h00;
        tick(1);
        n0 = n_acc;
        wmask(1'b1, 1'b0);
        tick(30);
        chk("held wake", 8'h01, {7'h00, (n_acc - n0) >= 8'h02});
        wclr(irwd_pkg::CLEAR_CODE_BASE);
        tick(10);
        n0 = n_acc;
        tick(20);
        chk("cleared wake", n0, n_acc);
        $display("test wake done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        tick(4);
        t_mask;
        t_prio;
        t_pin;
        t_level;
        t_wake;
        summarize;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        summarize;
    end
endmodule
